// ---- core/flash_protect_pkg.sv ----
/*
 * Constants and types for the flash program/erase protection block:
 * register offsets, field positions, reset values, block layout, overlay
 * window geometry, synchroniser layout, mode encoding and the state record.
 * Assumes an 8-bit register port and a byte-addressed flash of 256 KB.
 */
package flash_protect_pkg;

    localparam int REG_AW = 8;
    localparam int REG_DW = 8;
    localparam int NUM_BLOCKS = 12;
    localparam int SEL_ONE_BLOCKS = 4;
    localparam int FLASH_AW = 18;
    localparam int OVL_AW = 10;
    localparam int MODE_PIN_W = 4;

    // register offsets
    localparam logic [REG_AW-1:0] OFS_CTL_ONE = 8'h00;
    localparam logic [REG_AW-1:0] OFS_CTL_TWO = 8'h01;
    localparam logic [REG_AW-1:0] OFS_SEL_ONE = 8'h02;
    localparam logic [REG_AW-1:0] OFS_SEL_TWO = 8'h03;
    localparam logic [REG_AW-1:0] OFS_OVL_CTL = 8'h04;
    localparam logic [REG_AW-1:0] OFS_STATUS = 8'h05;

    // flash_control_one / flash_control_two fields
    localparam int BIT_START_P = 0;
    localparam int BIT_START_E = 1;
    localparam int BIT_VERIFY_P = 2;
    localparam int BIT_VERIFY_E = 3;
    localparam int BIT_SWE = 6;
    localparam int BIT_PIN_WE = 7;
    localparam int BIT_ERR = 7;

    // ram_overlay_control fields
    localparam int BIT_OVL_LO = 0;
    localparam int BIT_OVL_HI = 1;
    localparam int BIT_OVL_SEL = 3;

    // status fields
    localparam int BIT_ST_PROG = 0;
    localparam int BIT_ST_ERASE = 1;
    localparam int BIT_ST_PVER = 2;
    localparam int BIT_ST_EVER = 3;
    localparam int BIT_ST_ERR = 4;
    localparam int BIT_ST_PGMR = 5;
    localparam int BIT_ST_WP = 6;
    localparam int BIT_ST_OVL = 7;

    localparam logic [REG_DW-1:0] REG_RESET = 8'h00;
    localparam logic [REG_DW-1:0] READ_ZERO = 8'h00;

    localparam logic [MODE_PIN_W-1:0] PROGRAMMER_CODE = 4'hD;

    // overlay window: area code 01 lands on flash_block_eight
    localparam logic [1:0] OVL_CODE_BLOCK_EIGHT = 2'h1;
    localparam logic [FLASH_AW-1:0] OVL_BASE_BLOCK_EIGHT = 18'h3F000;

    // synchroniser layout: mode pins, write protect pin, standby_n pin
    localparam int SYNC_W = 6;
    localparam int SY_MODE = 0;
    localparam int SY_FWP = 4;
    localparam int SY_STBY_N = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h20;

    typedef enum logic [4:0] {
        MODE_IDLE = 5'b00001,
        MODE_PROGRAM = 5'b00010,
        MODE_ERASE = 5'b00100,
        MODE_PVERIFY = 5'b01000,
        MODE_EVERIFY = 5'b10000
    } mode_t;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic [SYNC_W-1:0] sync3;
        logic [SYNC_W-1:0] filt;
        logic [REG_DW-1:0] ctl_one;
        logic [REG_DW-1:0] ctl_two;
        logic [REG_DW-1:0] sel_one;
        logic [REG_DW-1:0] sel_two;
        logic [REG_DW-1:0] ovl_ctl;
        logic err;
        mode_t mode;
        logic [NUM_BLOCKS-1:0] blk_en;
        logic [REG_DW-1:0] rdata;
        logic ovl_hit;
        logic [OVL_AW-1:0] ovl_off;
    } state_t;

endpackage

// ---- core/flash_program_erase_protection.sv ----
/*
 * Flash program/erase protection: control registers, erase block
 * selection, error protection, RAM overlay decode and programmer-mode
 * pin handling for an on-chip flash array.
 * Assumes the CPU reaches the registers over a plain strobe port on CLK,
 * that the error event inputs come from logic on CLK, and that the pins
 * FLASH_WRITE_PROTECT_PIN, MODE_SELECT_PINS and HW_STANDBY_N are asynchronous.
 */
`timescale 1ns/1ps

module flash_program_erase_protection (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [flash_protect_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [flash_protect_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [flash_protect_pkg::REG_DW-1:0] REG_RDATA,
    input wire logic FLASH_WRITE_PROTECT_PIN,
    input wire logic [flash_protect_pkg::MODE_PIN_W-1:0] MODE_SELECT_PINS,
    input wire logic HW_STANDBY_N,
    input wire logic FLASH_READ,
    input wire logic EXCEPTION_DONE,
    input wire logic SLEEP_EXEC,
    input wire logic BUS_RELEASE,
    input wire logic ACCESS_VALID,
    input wire logic [flash_protect_pkg::FLASH_AW-1:0] ACCESS_ADDR,
    output logic OVERLAY_HIT,
    output logic [flash_protect_pkg::OVL_AW-1:0] OVERLAY_RAM_OFFSET,
    output logic PROGRAM_MODE,
    output logic ERASE_MODE,
    output logic PROGRAM_VERIFY_MODE,
    output logic ERASE_VERIFY_MODE,
    output logic [flash_protect_pkg::NUM_BLOCKS-1:0] ERASE_BLOCK_ENABLE,
    output logic FLASH_ERROR_FLAG,
    output logic PROGRAMMER_MODE,
    output logic FLASH_WRITE_ENABLE
);
    import flash_protect_pkg::*;

    logic rst_meta_ff;
    logic rst_sync_ff;
    state_t s_ff;
    state_t nxt_s;

    // derived levels
    logic standby;
    logic programmer;
    logic write_protect;
    logic busy;
    logic err_event;
    logic allowed;
    logic prog_req;
    logic erase_req;
    logic pver_req;
    logic ever_req;
    logic [1:0] ovl_idx;
    logic [FLASH_AW-1:0] ovl_base;
    logic [NUM_BLOCKS-1:0] blk_sel;
    logic [REG_DW-1:0] status;
    logic [REG_DW-1:0] rd_mux;
    logic [1:0] ovl_code;
    logic busy_prog;
    logic busy_erase;
    logic ev_read;
    logic ev_exception;
    logic ev_sleep;
    logic ev_bus;
    logic swe_set;
    logic emu_protect;
    logic hw_protect;
    logic any_block_sel;
    logic verify_ok;
    logic prog_go;
    logic erase_go;
    logic pver_go;
    logic ever_go;
    logic [FLASH_AW-OVL_AW-1:0] win_tag;
    logic [FLASH_AW-OVL_AW-1:0] acc_tag;
    logic win_match;
    logic [REG_DW-1:0] ctl_one_view;
    logic [REG_DW-1:0] ctl_two_view;

    // pin inputs and their filtered views
    logic [SYNC_W-1:0] pin_in;
    logic [SYNC_W-1:0] filt_nxt;
    logic [MODE_PIN_W-1:0] mode_pins_f;
    logic fwp_f;
    logic stby_n_f;

    // per-register write strobes and masked write data
    logic wr_ctl_one;
    logic wr_ctl_two;
    logic wr_sel_one;
    logic wr_sel_two;
    logic wr_ovl_ctl;
    logic [REG_DW-1:0] ctl_one_wdata;
    logic [REG_DW-1:0] ctl_two_wdata;
    logic [REG_DW-1:0] ovl_wdata;

    // reset release through two flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // block index to selection bit: blocks 0..3 in sel_one, 4..11 in sel_two
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_blk
            if (gi < SEL_ONE_BLOCKS) begin : g_one
                assign blk_sel[gi] = s_ff.sel_one[gi];
            end else begin : g_two
                assign blk_sel[gi] = s_ff.sel_two[gi - SEL_ONE_BLOCKS];
            end
        end
    endgenerate

    // per-pin filter: a change counts once stages two and three agree
    genvar gf;
    generate
        for (gf = 0; gf < SYNC_W; gf++) begin : g_filt
            assign filt_nxt[gf] = (s_ff.sync2[gf] == s_ff.sync3[gf]) ? s_ff.sync3[gf]
                : s_ff.filt[gf];
        end
    endgenerate

    always_comb begin
        pin_in[SY_MODE +: MODE_PIN_W] = MODE_SELECT_PINS;
        pin_in[SY_FWP] = FLASH_WRITE_PROTECT_PIN;
        pin_in[SY_STBY_N] = HW_STANDBY_N;
        mode_pins_f = s_ff.filt[SY_MODE +: MODE_PIN_W];
        fwp_f = s_ff.filt[SY_FWP];
        stby_n_f = s_ff.filt[SY_STBY_N];
        standby = !stby_n_f;
        programmer = mode_pins_f == PROGRAMMER_CODE;
        // active-high enable in programmer mode, active-high protect otherwise
        write_protect = programmer ? !fwp_f : fwp_f;
        hw_protect = write_protect || standby;
        busy_prog = s_ff.mode == MODE_PROGRAM;
        busy_erase = s_ff.mode == MODE_ERASE;
        busy = busy_prog || busy_erase;
        ev_read = FLASH_READ;
        ev_exception = EXCEPTION_DONE;
        ev_sleep = SLEEP_EXEC;
        ev_bus = BUS_RELEASE;
        err_event = busy
            && (ev_read
            || ev_exception
            || ev_sleep
            || ev_bus);
        prog_req = s_ff.ctl_one[BIT_START_P] || s_ff.ctl_two[BIT_START_P];
        erase_req = s_ff.ctl_one[BIT_START_E] || s_ff.ctl_two[BIT_START_E];
        pver_req = s_ff.ctl_one[BIT_VERIFY_P] || s_ff.ctl_two[BIT_VERIFY_P];
        ever_req = s_ff.ctl_one[BIT_VERIFY_E] || s_ff.ctl_two[BIT_VERIFY_E];
        swe_set = s_ff.ctl_one[BIT_SWE];
        emu_protect = s_ff.ovl_ctl[BIT_OVL_SEL];
        any_block_sel = blk_sel != '0;
        verify_ok = !hw_protect;

        // overlay window decode
        ovl_code = {s_ff.ovl_ctl[BIT_OVL_HI], s_ff.ovl_ctl[BIT_OVL_LO]};
        ovl_idx = ovl_code - OVL_CODE_BLOCK_EIGHT;
        ovl_base = OVL_BASE_BLOCK_EIGHT + FLASH_AW'({ovl_idx, {OVL_AW{1'b0}}});
        win_tag = ovl_base[FLASH_AW-1:OVL_AW];
        acc_tag = ACCESS_ADDR[FLASH_AW-1:OVL_AW];
        win_match = ACCESS_VALID && emu_protect && (acc_tag == win_tag);

        // write data with hardware-owned bits masked off
        wr_ctl_one = REG_WR && (REG_ADDR == OFS_CTL_ONE);
        wr_ctl_two = REG_WR && (REG_ADDR == OFS_CTL_TWO);
        wr_sel_one = REG_WR && (REG_ADDR == OFS_SEL_ONE);
        wr_sel_two = REG_WR && (REG_ADDR == OFS_SEL_TWO);
        wr_ovl_ctl = REG_WR && (REG_ADDR == OFS_OVL_CTL);
        ctl_one_wdata = REG_WDATA;
        ctl_one_wdata[BIT_PIN_WE] = 1'b0;
        ctl_two_wdata = REG_WDATA;
        ctl_two_wdata[BIT_ERR] = 1'b0;
        ctl_two_wdata[BIT_SWE] = 1'b0;
        ovl_wdata = READ_ZERO;
        ovl_wdata[BIT_OVL_SEL] = REG_WDATA[BIT_OVL_SEL];
        ovl_wdata[BIT_OVL_HI] = REG_WDATA[BIT_OVL_HI];
        ovl_wdata[BIT_OVL_LO] = REG_WDATA[BIT_OVL_LO];

        ctl_one_view = s_ff.ctl_one;
        ctl_one_view[BIT_PIN_WE] = !write_protect;
        ctl_two_view = s_ff.ctl_two;
        ctl_two_view[BIT_ERR] = s_ff.err;

        status = READ_ZERO;
        status[BIT_ST_PROG] = s_ff.mode == MODE_PROGRAM;
        status[BIT_ST_ERASE] = s_ff.mode == MODE_ERASE;
        status[BIT_ST_PVER] = s_ff.mode == MODE_PVERIFY;
        status[BIT_ST_EVER] = s_ff.mode == MODE_EVERIFY;
        status[BIT_ST_ERR] = s_ff.err;
        status[BIT_ST_PGMR] = programmer;
        status[BIT_ST_WP] = write_protect;
        status[BIT_ST_OVL] = s_ff.ovl_ctl[BIT_OVL_SEL];

        unique case (REG_ADDR)
            OFS_CTL_ONE: begin
                rd_mux = ctl_one_view;
            end
            OFS_CTL_TWO: begin
                rd_mux = ctl_two_view;
            end
            OFS_SEL_ONE: begin
                rd_mux = s_ff.sel_one;
            end
            OFS_SEL_TWO: begin
                rd_mux = s_ff.sel_two;
            end
            OFS_OVL_CTL: begin
                rd_mux = s_ff.ovl_ctl;
            end
            OFS_STATUS: begin
                rd_mux = status;
            end
            default: begin
                rd_mux = READ_ZERO;
            end
        endcase
    end

    always_comb begin
        nxt_s = s_ff;

        // pin synchronisers: a change counts once stages two and three agree
        nxt_s.sync1 = pin_in;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.sync3 = s_ff.sync2;
        nxt_s.filt = filt_nxt;

        // register writes; hardware-owned bits never take software data
        if (wr_ctl_one) begin
            nxt_s.ctl_one = ctl_one_wdata;
        end
        if (wr_ctl_two) begin
            nxt_s.ctl_two = ctl_two_wdata;
        end
        if (wr_sel_one) begin
            nxt_s.sel_one = REG_WDATA;
        end
        if (wr_sel_two) begin
            nxt_s.sel_two = REG_WDATA;
        end
        if (wr_ovl_ctl) begin
            nxt_s.ovl_ctl = ovl_wdata;
        end

        // pin or standby protection initialises the control set
        if (write_protect || standby) begin
            nxt_s.ctl_one = REG_RESET;
            nxt_s.ctl_two = REG_RESET;
            nxt_s.sel_one = REG_RESET;
            nxt_s.sel_two = REG_RESET;
        end

        // error flag: set by events, cleared only by standby (reset elsewhere)
        if (standby) begin
            nxt_s.err = 1'b0;
        end
        if (err_event) begin
            nxt_s.err = 1'b1;
        end

        // entry qualification; registers are kept on error
        allowed = swe_set
            && !emu_protect
            && !nxt_s.err
            && !hw_protect;

        // go terms for each mode, program first
        prog_go = allowed && prog_req;
        erase_go = allowed && erase_req && any_block_sel;
        pver_go = pver_req && verify_ok;
        ever_go = ever_req && verify_ok;
        if (prog_go) begin
            nxt_s.mode = MODE_PROGRAM;
        end else if (erase_go) begin
            nxt_s.mode = MODE_ERASE;
        end else if (pver_go) begin
            nxt_s.mode = MODE_PVERIFY;
        end else if (ever_go) begin
            nxt_s.mode = MODE_EVERIFY;
        end else begin
            nxt_s.mode = MODE_IDLE;
        end

        if (nxt_s.mode == MODE_ERASE) begin
            nxt_s.blk_en = blk_sel;
        end else begin
            nxt_s.blk_en = '0;
        end

        // read data stands in the cycle after the strobe only
        if (REG_RD) begin
            nxt_s.rdata = rd_mux;
        end else begin
            nxt_s.rdata = READ_ZERO;
        end

        // overlay: flash addresses inside the window reach the RAM copy
        nxt_s.ovl_hit = win_match;
        nxt_s.ovl_off = ACCESS_ADDR[OVL_AW-1:0];
    end

    always_ff @(posedge CLK or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            s_ff <= '{
                sync1: SYNC_RESET,
                sync2: SYNC_RESET,
                sync3: SYNC_RESET,
                filt: SYNC_RESET,
                ctl_one: REG_RESET,
                ctl_two: REG_RESET,
                sel_one: REG_RESET,
                sel_two: REG_RESET,
                ovl_ctl: REG_RESET,
                err: 1'b0,
                mode: MODE_IDLE,
                blk_en: '0,
                rdata: READ_ZERO,
                ovl_hit: 1'b0,
                ovl_off: '0
            };
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign REG_RDATA = s_ff.rdata;
    assign OVERLAY_HIT = s_ff.ovl_hit;
    assign OVERLAY_RAM_OFFSET = s_ff.ovl_off;
    assign PROGRAM_MODE = s_ff.mode == MODE_PROGRAM;
    assign ERASE_MODE = s_ff.mode == MODE_ERASE;
    assign PROGRAM_VERIFY_MODE = s_ff.mode == MODE_PVERIFY;
    assign ERASE_VERIFY_MODE = s_ff.mode == MODE_EVERIFY;
    assign ERASE_BLOCK_ENABLE = s_ff.blk_en;
    assign FLASH_ERROR_FLAG = s_ff.err;
    assign PROGRAMMER_MODE = programmer;
    assign FLASH_WRITE_ENABLE = !write_protect;

endmodule // flash_program_erase_protection

// ---- bench/flash_protect_sva.sv ----
/* protection block port checker, bound to the top module;
   assumes the error event inputs are on CLK */
`timescale 1ns/1ps
module flash_protect_sva (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic FLASH_WRITE_PROTECT_PIN,
    input wire logic [flash_protect_pkg::MODE_PIN_W-1:0] MODE_SELECT_PINS,
    input wire logic HW_STANDBY_N,
    input wire logic FLASH_READ,
    input wire logic EXCEPTION_DONE,
    input wire logic SLEEP_EXEC,
    input wire logic BUS_RELEASE,
    input wire logic ACCESS_VALID,
    input wire logic [flash_protect_pkg::FLASH_AW-1:0] ACCESS_ADDR,
    input wire logic OVERLAY_HIT,
    input wire logic [flash_protect_pkg::OVL_AW-1:0] OVERLAY_RAM_OFFSET,
    input wire logic PROGRAM_MODE,
    input wire logic ERASE_MODE,
    input wire logic [flash_protect_pkg::NUM_BLOCKS-1:0] ERASE_BLOCK_ENABLE,
    input wire logic FLASH_ERROR_FLAG,
    input wire logic PROGRAMMER_MODE,
    input wire logic FLASH_WRITE_ENABLE
);
    import flash_protect_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic [3:0] stby_cnt_ff;
    // standby seen recently, error may clear
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) stby_cnt_ff <= 4'h0;
        else if (!HW_STANDBY_N) stby_cnt_ff <= 4'hF;
        else if (stby_cnt_ff != 4'h0) stby_cnt_ff <= stby_cnt_ff - 4'h1;
    end
    property p_err(ev);
        (PROGRAM_MODE || ERASE_MODE) && ev |=> FLASH_ERROR_FLAG && !PROGRAM_MODE && !ERASE_MODE;
    endproperty
    a_read_sets_err: assert property (p_err(FLASH_READ)) else $error("flash read kept mode");
    a_exc_sets_err: assert property (p_err(EXCEPTION_DONE)) else $error("exception kept mode");
    a_sleep_sets_err: assert property (p_err(SLEEP_EXEC)) else $error("sleep kept mode");
    a_bus_sets_err: assert property (p_err(BUS_RELEASE)) else $error("bus release kept mode");
    a_error_blocks_mode: assert property (FLASH_ERROR_FLAG |-> !PROGRAM_MODE && !ERASE_MODE)
        else $error("mode entered under error");
    a_error_sticky: assert property ($fell(FLASH_ERROR_FLAG) |-> stby_cnt_ff != 4'h0)
        else $error("error cleared without standby");
    a_erase_gate: assert property (ERASE_MODE == (ERASE_BLOCK_ENABLE != 12'h000))
        else $error("erase mode and block enables disagree");
    a_overlay_hit: assert property (OVERLAY_HIT |-> ($past(ACCESS_ADDR) >> 12) == 18'h0003F)
        else $error("overlay hit outside window");
    a_overlay_offset: assert property (ACCESS_VALID |=>
        {8'h00, OVERLAY_RAM_OFFSET} == ($past(ACCESS_ADDR) & 18'h003FF)) else $error("bad offset");
    a_pin_protect: assert property (!FLASH_WRITE_ENABLE [*3] |-> !PROGRAM_MODE && !ERASE_MODE)
        else $error("mode under pin protect");
    a_pin_polarity: assert property (($stable(FLASH_WRITE_PROTECT_PIN)
        && $stable(MODE_SELECT_PINS)) [*8] |-> FLASH_WRITE_ENABLE ==
        (FLASH_WRITE_PROTECT_PIN ^ (MODE_SELECT_PINS != PROGRAMMER_CODE))) else $error("pin sense");
    c_erase: cover property (ERASE_MODE);
    c_error: cover property ($rose(FLASH_ERROR_FLAG));
    c_hit: cover property (OVERLAY_HIT);
    c_pgmr: cover property (PROGRAMMER_MODE && FLASH_WRITE_ENABLE);
endmodule // flash_protect_sva
bind flash_program_erase_protection flash_protect_sva chk (.CLK(CLK), .RESET_N(RESET_N),
    .FLASH_WRITE_PROTECT_PIN(FLASH_WRITE_PROTECT_PIN), .MODE_SELECT_PINS(MODE_SELECT_PINS),
    .HW_STANDBY_N(HW_STANDBY_N), .FLASH_READ(FLASH_READ), .EXCEPTION_DONE(EXCEPTION_DONE),
    .SLEEP_EXEC(SLEEP_EXEC), .BUS_RELEASE(BUS_RELEASE), .ACCESS_VALID(ACCESS_VALID),
    .ACCESS_ADDR(ACCESS_ADDR), .OVERLAY_HIT(OVERLAY_HIT), .OVERLAY_RAM_OFFSET(OVERLAY_RAM_OFFSET),
    .PROGRAM_MODE(PROGRAM_MODE), .ERASE_MODE(ERASE_MODE), .ERASE_BLOCK_ENABLE(ERASE_BLOCK_ENABLE),
    .FLASH_ERROR_FLAG(FLASH_ERROR_FLAG), .PROGRAMMER_MODE(PROGRAMMER_MODE),
    .FLASH_WRITE_ENABLE(FLASH_WRITE_ENABLE));

// ---- bench/pin_programmer_model.sv ----
/* external programmer pin setup model;
   assumes requests change at the rising edge of CLK */
`timescale 1ns/1ps
module pin_programmer_model (
    input wire logic CLK,
    input wire logic programmer_req,
    input wire logic protect_req,
    output logic [flash_protect_pkg::MODE_PIN_W-1:0] mode_pins = 4'h0,
    output logic write_protect_pin = 1'b0
);
    import flash_protect_pkg::*;
    always @(posedge CLK) begin
        mode_pins <= programmer_req ? PROGRAMMER_CODE : 4'h0;
        // in programmer mode the pin is a write enable, held high to write
        write_protect_pin <= programmer_req ? !protect_req : protect_req;
    end
endmodule // pin_programmer_model

// ---- bench/flash_program_erase_protection_test.sv ----
/* self-checking bench for the protection block;
   assumes the pin model and the bound checker */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module flash_program_erase_protection_test;
    import flash_protect_pkg::*;
    logic CLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, HW_STANDBY_N = 1;
    logic ACCESS_VALID = 0, prog_req = 0, prot_req = 0;
    logic [3:0] ev = 4'h0;
    logic [REG_AW-1:0] REG_ADDR = 8'h00;
    logic [REG_DW-1:0] REG_WDATA = 8'h00, REG_RDATA;
    logic [FLASH_AW-1:0] ACCESS_ADDR = 18'h00000;
    logic [MODE_PIN_W-1:0] pins;
    logic wp_pin, hit, pm, em, pvm, evm, err, pgm, we;
    logic [OVL_AW-1:0] ofs;
    logic [NUM_BLOCKS-1:0] blk;
    int errors = 0, comparisons = 0;
    pin_programmer_model pmod (.CLK(CLK), .programmer_req(prog_req), .protect_req(prot_req),
        .mode_pins(pins), .write_protect_pin(wp_pin));
    flash_program_erase_protection uut (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .FLASH_WRITE_PROTECT_PIN(wp_pin), .MODE_SELECT_PINS(pins), .HW_STANDBY_N(HW_STANDBY_N),
        .FLASH_READ(ev[0]), .EXCEPTION_DONE(ev[1]), .SLEEP_EXEC(ev[2]), .BUS_RELEASE(ev[3]),
        .ACCESS_VALID(ACCESS_VALID), .ACCESS_ADDR(ACCESS_ADDR), .OVERLAY_HIT(hit),
        .OVERLAY_RAM_OFFSET(ofs), .PROGRAM_MODE(pm), .ERASE_MODE(em), .PROGRAM_VERIFY_MODE(pvm),
        .ERASE_VERIFY_MODE(evm), .ERASE_BLOCK_ENABLE(blk), .FLASH_ERROR_FLAG(err),
        .PROGRAMMER_MODE(pgm), .FLASH_WRITE_ENABLE(we));
    initial begin
        forever #2 CLK = ~CLK;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // returns once the mode decode reflects the write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        `CHK("read data", e, REG_RDATA)
    endtask
    task automatic acc(input logic [17:0] a, input logic h);
        @(posedge CLK);
        ACCESS_VALID <= 1'b1;
        ACCESS_ADDR <= a;
        @(posedge CLK);
        ACCESS_VALID <= 1'b0;
        #1;
        `CHK("overlay hit", h, hit)
        `CHK("overlay offset", a[9:0], ofs)
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #80000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        tick(3);
        rd(OFS_CTL_ONE, 8'h80);
        for (int a = 1; a < 6; a++) rd(a[7:0], READ_ZERO);
        rd(8'h3C, READ_ZERO);
        wr(OFS_CTL_ONE, 8'h01);
        `CHK("modes", 4'h0, {pm, em, pvm, evm})
        wr(OFS_CTL_ONE, 8'h41);
        `CHK("modes", 4'h8, {pm, em, pvm, evm})
        for (int c = 0; c < 4; c++) begin
            wr(OFS_OVL_CTL, 8'h08 | c[7:0]);
            `CHK("program mode", 1'b0, pm)
        end
        wr(OFS_OVL_CTL, 8'h09);
        acc(18'h3F123, 1'b1);
        acc(18'h3F523, 1'b0);
        wr(OFS_OVL_CTL, 8'h00);
        acc(18'h3F123, 1'b0);
        `CHK("program mode", 1'b1, pm)
        wr(OFS_CTL_ONE, 8'h42);
        `CHK("erase mode", 1'b0, em)
        wr(OFS_CTL_TWO, 8'h01);
        `CHK("modes", 4'h8, {pm, em, pvm, evm})
        wr(OFS_CTL_TWO, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SEL_ONE, 8'h05);
            wr(OFS_SEL_TWO, 8'h10);
            wr(OFS_CTL_ONE, 8'h42);
            `CHK("blocks", 12'h105, blk)
            rd(OFS_STATUS, 8'h02);
            @(posedge CLK);
            ev <= 4'(1 << i);
            @(posedge CLK);
            ev <= 4'h0;
            #1;
            `CHK("error flag", 1'b1, err)
            `CHK("modes", 4'h0, {pm, em, pvm, evm})
            rd(OFS_CTL_ONE, 8'hC2);
            rd(OFS_SEL_ONE, 8'h05);
            rd(OFS_CTL_TWO, 8'h80);
            wr(OFS_CTL_ONE, 8'h41);
            `CHK("program mode", 1'b0, pm)
            wr(OFS_CTL_TWO, 8'h08);
            `CHK("erase verify", 1'b1, evm)
            wr(OFS_CTL_TWO, 8'h04);
            `CHK("program verify", 1'b1, pvm)
            wr(OFS_CTL_TWO, 8'h00);
            `CHK("error flag", 1'b1, err)
            @(posedge CLK);
            HW_STANDBY_N <= 1'b0;
            tick(8);
            @(posedge CLK);
            HW_STANDBY_N <= 1'b1;
            tick(8);
            `CHK("error flag", 1'b0, err)
            rd(OFS_CTL_ONE, 8'h80);
        end
        wr(OFS_CTL_ONE, 8'h41);
        `CHK("program mode", 1'b1, pm)
        @(posedge CLK);
        prot_req <= 1'b1;
        tick(8);
        `CHK("program mode", 1'b0, pm)
        rd(OFS_CTL_ONE, 8'h00);
        @(posedge CLK);
        prot_req <= 1'b0;
        prog_req <= 1'b1;
        tick(8);
        `CHK("programmer pins", 2'h3, {pgm, we})
        rd(OFS_STATUS, 8'h20);
        @(posedge CLK);
        prot_req <= 1'b1;
        tick(8);
        `CHK("programmer pins", 2'h2, {pgm, we})
        tally_and_finish();
    end
endmodule // flash_program_erase_protection_test
